// file: design/crr_half_router.sv
`default_nettype none
module crr_half_router
    import crr_pkg::*;
(
    input  wire logic [2:0] reg_phase_in,
    input  wire logic       rev_in,
    input  wire logic       sum_hold_in,
    output crr_half_t       half_out
);
    // Register phase routing and summing well for one half
    always_comb begin
        if (rev_in) begin
            half_out.elec = reg_phase_in;
        end else begin
            half_out.elec = {reg_phase_in[2], reg_phase_in[0], reg_phase_in[1]};
        end
        // Held high while binning, else follows phase three
        half_out.sum_well = sum_hold_in | reg_phase_in[2];
    end
endmodule : crr_half_router
`default_nettype wire

// file: design/crr_pkg.sv
`default_nettype none
package crr_pkg;
    // Clock period and register clock minimum
    localparam int CLK_PERIOD_NS   = 5;
    localparam int REG_PERIOD_MIN_NS = 300;
    // Least register clock period in core cycles, rounded up
    localparam int REG_PERIOD_MIN_CYC = (REG_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int THIRD_CYC       = (REG_PERIOD_MIN_CYC + 2) / 3;
    localparam int CNT_W           = 8;
    localparam int SUM_W           = 4;
    localparam logic [SUM_W-1:0] SUM_DEFAULT = 4'h1;
    localparam int SUP_W           = 16;
    localparam logic [SUP_W-1:0] SUP_SETTLE_DEFAULT = 16'h0400;
    // Line transfer overlap step count per image phase step
    localparam logic [CNT_W-1:0] IMG_STEP_CYC = 8'h10;

    // Four image sections, four register halves
    localparam int NSEC = 4;
    localparam int NHALF = 4;
    localparam int SEC_A = 0;
    localparam int SEC_D = 3;

    typedef enum logic [2:0] {
        CRR_SUP_OFF, CRR_SUP_DRAINS, CRR_SUP_SUBST, CRR_SUP_ON, CRR_SUP_SUBDOWN
    } crr_sup_t;

    typedef enum logic [2:0] {
        CRR_IDLE, CRR_INTEG, CRR_LINE, CRR_SHIFT
    } crr_seq_t;

    // Electrode drives for one image section (bit n = electrode n+1)
    typedef struct packed {
        logic [3:0] elec;
    } crr_sec_t;

    // Electrode drives for one register half (bit n = electrode n+1) plus summing well
    typedef struct packed {
        logic [2:0] elec;
        logic       sum_well;
    } crr_half_t;

    // Supply enables
    typedef struct packed {
        logic drains_on;
        logic subst_on;
    } crr_supply_t;

    // User command bundle
    typedef struct packed {
        logic [NSEC-1:0]  sec_rev;
        logic [NHALF-1:0] half_rev;
        logic [SUM_W-1:0] sum_count;
        logic [CNT_W-1:0] pixels;
    } crr_cfg_t;
endpackage : crr_pkg
`default_nettype wire

// file: design/crr_readout_ctrl.sv
`default_nettype none
// Operation
// - Section A forward: phases 1-4, gate=phase4
// - Forward B up, C down, ascending order
// - Section D forward: phases 1-4, gate=phase1
// - Section A reverse: descending, gate low
// - Reverse B down, C up, descending
// - Section D reverse: descending, gate low
// - Full upper readout: A,B forward; C,D reverse
// - Register phases 1,2 high during transfer
// - Local output: phase1->e2, phase2->e1, phase3->e3
// - Reverse half: phases map straight through
// - No summing: well follows phase three
// - Binning: hold well high, release every Nth pixel
// - Drains up before substrate rises
// - Substrate to zero before drains off
// - Mode chosen only by clock sequences
// - Integration: image phases 2,3 high
// - Register period never below 300 ns
module crr_readout_ctrl
    import crr_pkg::*;
#(
    parameter logic [SUP_W-1:0] SUP_SETTLE_CYC = SUP_SETTLE_DEFAULT
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 power_req_in,
    input  wire logic                 cfg_load_in,
    input  wire crr_cfg_t             cfg_in,
    input  wire logic                 integrate_in,
    input  wire logic                 line_start_in,
    output logic [NSEC-1:0][3:0]      img_elec_out,
    output logic                      upper_section_transfer_gate_out,
    output logic                      lower_section_transfer_gate_out,
    output logic [NHALF-1:0][3:0]     reg_elec_out,
    output crr_supply_t               supply_out,
    output logic                      busy_out,
    output logic                      powered_out
);
    typedef struct packed {
        crr_sup_t         sup;
        logic [SUP_W-1:0] sup_cnt;
        crr_seq_t         seq;
        crr_cfg_t         cfg;
        logic [CNT_W-1:0] cnt;
        logic [2:0]       step;
        logic [CNT_W-1:0] pix;
        logic [SUM_W-1:0] sum_left;
        logic [3:0]       iph;
        logic [2:0]       rph;
        logic [CNT_W-1:0] rph_age;
        logic [NSEC-1:0][3:0]  img;
        logic             up_gate;
        logic             lo_gate;
        logic             busy;
        logic             powered;
        logic [NHALF-1:0][3:0] regs;
        crr_supply_t      supply;
    } crr_state_t;

    crr_state_t st_r;
    crr_state_t st_nxt;
    crr_half_t  half_w [NHALF];
    logic       sum_hold_w;

    // Summing well held while binned pixels remain
    assign sum_hold_w = (st_r.seq == CRR_SHIFT) && (st_r.sum_left > SUM_W'(1));

    // One router per register half
    genvar gh;
    generate
        for (gh = 0; gh < NHALF; gh++) begin : g_half
            crr_half_router u_half (
                .reg_phase_in (st_r.rph),
                .rev_in       (st_r.cfg.half_rev[gh]),
                .sum_hold_in  (sum_hold_w),
                .half_out     (half_w[gh])
            );
        end
    endgenerate

    // Next state: supply sequencer, readout sequencer, electrode routing
    always_comb begin
        st_nxt = st_r;
        // Supply order: drains then substrate, reverse on the way down
        unique case (st_r.sup)
            CRR_SUP_OFF: begin
                if (power_req_in) begin
                    st_nxt.sup = CRR_SUP_DRAINS;
                    st_nxt.sup_cnt = '0;
                    st_nxt.supply.drains_on = 1'b1;
                end
            end
            CRR_SUP_DRAINS: begin
                st_nxt.sup_cnt = st_r.sup_cnt + SUP_W'(1);
                if (st_r.sup_cnt == SUP_SETTLE_CYC) begin
                    st_nxt.sup = CRR_SUP_SUBST;
                    st_nxt.supply.subst_on = 1'b1;
                end
            end
            CRR_SUP_SUBST: begin
                st_nxt.sup = CRR_SUP_ON;
            end
            CRR_SUP_ON: begin
                if (!power_req_in && st_r.seq == CRR_IDLE) begin
                    st_nxt.sup = CRR_SUP_SUBDOWN;
                    st_nxt.sup_cnt = '0;
                    st_nxt.supply.subst_on = 1'b0;
                end
            end
            CRR_SUP_SUBDOWN: begin
                st_nxt.sup_cnt = st_r.sup_cnt + SUP_W'(1);
                if (st_r.sup_cnt == SUP_SETTLE_CYC) begin
                    st_nxt.sup = CRR_SUP_OFF;
                    st_nxt.supply.drains_on = 1'b0;
                end
            end
            default: begin
                st_nxt.sup = CRR_SUP_OFF;
                st_nxt.supply = '0;
            end
        endcase

        // Readout sequencer; mode is purely the choice of directions
        unique case (st_r.seq)
            CRR_IDLE: begin
                st_nxt.iph = 4'h0;
                st_nxt.rph = 3'h0;
                if (cfg_load_in) begin
                    st_nxt.cfg = cfg_in;
                    if (cfg_in.sum_count == '0) begin
                        st_nxt.cfg.sum_count = SUM_DEFAULT;
                    end
                end else if (st_r.sup == CRR_SUP_ON && integrate_in) begin
                    st_nxt.seq = CRR_INTEG;
                end else if (st_r.sup == CRR_SUP_ON && line_start_in) begin
                    st_nxt.seq = CRR_LINE;
                    st_nxt.cnt = '0;
                    st_nxt.step = 3'h0;
                end
            end
            CRR_INTEG: begin
                st_nxt.iph = 4'h6;
                st_nxt.rph = 3'h0;
                if (!integrate_in) begin
                    st_nxt.seq = CRR_IDLE;
                end
            end
            CRR_LINE: begin
                // Register phases 1 and 2 high while charge enters them
                st_nxt.rph = 3'h3;
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
                if (st_r.cnt == IMG_STEP_CYC) begin
                    st_nxt.cnt = '0;
                    st_nxt.step = st_r.step + 3'h1;
                    // Overlapping four-phase walk: 0110,1100,1001,0011,0110
                    unique case (st_r.step)
                        3'h0: st_nxt.iph = 4'h6;
                        3'h1: st_nxt.iph = 4'hC;
                        3'h2: st_nxt.iph = 4'h9;
                        3'h3: st_nxt.iph = 4'h3;
                        3'h4: st_nxt.iph = 4'h6;
                        default: begin
                            st_nxt.seq = CRR_SHIFT;
                            st_nxt.pix = st_r.cfg.pixels;
                            st_nxt.sum_left = st_r.cfg.sum_count;
                            st_nxt.rph = 3'h1;
                        end
                    endcase
                end
            end
            CRR_SHIFT: begin
                // Three-phase register clock; each third lasts THIRD_CYC
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
                if (st_r.cnt == CNT_W'(THIRD_CYC - 1)) begin
                    st_nxt.cnt = '0;
                    st_nxt.rph = {st_r.rph[1:0], st_r.rph[2]};
                    if (st_r.rph[2]) begin
                        // One pixel clocked; well releases after sum_count pixels
                        st_nxt.sum_left = (st_r.sum_left > SUM_W'(1)) ?
                            st_r.sum_left - SUM_W'(1) : st_r.cfg.sum_count;
                        if (st_r.pix == '0) begin
                            st_nxt.seq = CRR_IDLE;
                            st_nxt.rph = 3'h0;
                        end else begin
                            st_nxt.pix = st_r.pix - CNT_W'(1);
                        end
                    end
                end
            end
            default: st_nxt.seq = CRR_IDLE;
        endcase

        // Image section routing from direction selects
        for (int s = 0; s < NSEC; s++) begin
            if (st_r.cfg.sec_rev[s]) begin
                st_nxt.img[s] = {st_nxt.iph[0], st_nxt.iph[1], st_nxt.iph[2], st_nxt.iph[3]};
            end else begin
                st_nxt.img[s] = st_nxt.iph;
            end
        end
        st_nxt.up_gate = st_r.cfg.sec_rev[SEC_A] ? 1'b0 : st_nxt.iph[3];
        st_nxt.lo_gate = st_r.cfg.sec_rev[SEC_D] ? 1'b0 : st_nxt.iph[0];
        // Age of the register phase pattern, saturating so it never wraps into a false short period
        if (st_nxt.rph != st_r.rph) begin
            st_nxt.rph_age = '0;
        end else if (st_r.rph_age != '1) begin
            st_nxt.rph_age = st_r.rph_age + CNT_W'(1);
        end
        // Status levels registered so the outputs come straight from flip-flops
        st_nxt.busy = (st_nxt.seq != CRR_IDLE);
        st_nxt.powered = (st_nxt.sup == CRR_SUP_ON);
        for (int h = 0; h < NHALF; h++) begin
            st_nxt.regs[h] = {half_w[h].sum_well, half_w[h].elec};
        end
    end

    // State register; all outputs come from it
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= '{sup: CRR_SUP_OFF, seq: CRR_IDLE,
                      cfg: '{sec_rev: 4'h0, half_rev: 4'h0, sum_count: SUM_DEFAULT, pixels: 8'h00},
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign img_elec_out = st_r.img;
    assign upper_section_transfer_gate_out = st_r.up_gate;
    assign lower_section_transfer_gate_out = st_r.lo_gate;
    assign reg_elec_out = st_r.regs;
    assign supply_out = st_r.supply;
    assign busy_out = st_r.busy;
    assign powered_out = st_r.powered;

    // Assertions
    property p_up_gate_rev;
        @(posedge core_clk_in) disable iff (!rstn_in)
        st_r.cfg.sec_rev[SEC_A] |=> !upper_section_transfer_gate_out || !$past(st_r.cfg.sec_rev[SEC_A]);
    endproperty
    a_up_gate_rev: assert property (p_up_gate_rev) else $error("gate A not low in reverse");
    property p_subst;
        @(posedge core_clk_in) disable iff (!rstn_in)
        supply_out.subst_on |-> supply_out.drains_on;
    endproperty
    a_subst: assert property (p_subst) else $error("substrate on without drains");
    property p_xfer;
        @(posedge core_clk_in) disable iff (!rstn_in)
        $past(st_r.seq == CRR_LINE) && st_r.seq == CRR_LINE |-> st_r.rph == 3'h3;
    endproperty
    a_xfer: assert property (p_xfer) else $error("register phases low in transfer");
    property p_integ;
        @(posedge core_clk_in) disable iff (!rstn_in)
        st_r.seq == CRR_INTEG ##1 st_r.seq == CRR_INTEG |-> st_r.iph == 4'h6;
    endproperty
    a_integ: assert property (p_integ) else $error("integration phases wrong");
    // Each register phase third must have stood its full length before the pattern moves on
    property p_shift_hold;
        @(posedge core_clk_in) disable iff (!rstn_in)
        st_r.seq == CRR_SHIFT && st_nxt.seq == CRR_SHIFT && st_nxt.rph != st_r.rph
            |-> st_r.rph_age >= CNT_W'(THIRD_CYC - 1);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("register clock too fast");
    property p_fwd;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !st_r.cfg.sec_rev[1] && $stable(st_r.cfg) |-> img_elec_out[1] == $past(st_nxt.iph);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward routing wrong");
    property p_lo_gate_fwd;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !st_r.cfg.sec_rev[SEC_D] && $stable(st_r.cfg) |-> lower_section_transfer_gate_out == img_elec_out[SEC_D][0];
    endproperty
    a_lo_gate_fwd: assert property (p_lo_gate_fwd) else $error("gate D not phase one");
    property p_sum;
        @(posedge core_clk_in) disable iff (!rstn_in)
        st_r.seq == CRR_SHIFT && st_r.cfg.sum_count == SUM_DEFAULT |=> reg_elec_out[0][3] == reg_elec_out[0][2];
    endproperty
    a_sum: assert property (p_sum) else $error("well not following phase three");
endmodule : crr_readout_ctrl
`default_nettype wire

// file: verif/crr_sensor_model.sv
`default_nettype none
module crr_sensor_model
    import crr_pkg::*;
(
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic [NSEC-1:0][3:0] img_elec_in,
    input  wire logic [NHALF-1:0][3:0] reg_elec_in,
    input  wire crr_supply_t          supply_in,
    output logic [7:0]                viol_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] gap_r;
    logic       e3_prev_r;
    logic       seen_rise_r;

    // The sensor has no mode pins: mode only shows through the clocks it sees
    // Flags three abuses that could damage the part or lose charge: supply order, transfer hold, short register period
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            viol_out    <= 8'h00;
            gap_r       <= 8'h00;
            e3_prev_r   <= 1'b0;
            seen_rise_r <= 1'b0;
        end else begin
            e3_prev_r <= reg_elec_in[0][2];
            if (gap_r != 8'hFF) begin
                gap_r <= gap_r + 8'h01;
            end
            // Drains must never sit below a raised substrate
            if (supply_in.subst_on && !supply_in.drains_on) begin
                viol_out <= viol_out + 8'h01;
            end
            // Charge arriving from the image needs register phases 1,2 high
            for (int h = 0; h < NHALF; h++) begin
                // Parked patterns (all low, integration) move no charge
                if (img_elec_in[0] != 4'h6 && img_elec_in[0] != 4'h0 && reg_elec_in[h][1:0] != 2'h3) begin
                    viol_out <= viol_out + 8'h01;
                end
            end
            // Register period too short corrupts the serial transfer
            if (reg_elec_in[0][2] && !e3_prev_r) begin
                gap_r       <= 8'h01;
                seen_rise_r <= 1'b1;
                if (seen_rise_r && gap_r < 8'(REG_PERIOD_MIN_CYC)) begin
                    viol_out <= viol_out + 8'h01;
                end
            end
        end
    end
endmodule : crr_sensor_model
`default_nettype wire

// file: verif/tb_ccd_readout_clock_router.sv
`default_nettype none
module tb_ccd_readout_clock_router
    import crr_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [SUP_W-1:0] SETTLE = 16'h0004; // Short settle keeps the run brief
    localparam logic [CNT_W-1:0] PIX    = 8'h03;

    logic                  core_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  power_req = 1'b0;
    logic                  cfg_load = 1'b0;
    crr_cfg_t              cfg = '0;
    logic                  integrate = 1'b0;
    logic                  line_start = 1'b0;
    logic [NSEC-1:0][3:0]  img;
    logic                  tg_up;
    logic                  tg_lo;
    logic [NHALF-1:0][3:0] regs;
    crr_supply_t           supply;
    logic                  busy;
    logic                  powered;
    logic [7:0]            viol;
    int                    fail_count = 0;
    int                    samples_checked = 0;
    int                    cycles = 0;

    always #2.5 core_clk = ~core_clk;

    crr_readout_ctrl #(.SUP_SETTLE_CYC(SETTLE)) DUT (
        .core_clk_in(core_clk), .rstn_in(rstn), .power_req_in(power_req), .cfg_load_in(cfg_load),
        .cfg_in(cfg), .integrate_in(integrate), .line_start_in(line_start), .img_elec_out(img),
        .upper_section_transfer_gate_out(tg_up), .lower_section_transfer_gate_out(tg_lo),
        .reg_elec_out(regs), .supply_out(supply), .busy_out(busy), .powered_out(powered));

    crr_sensor_model u_sensor (
        .core_clk_in(core_clk), .rstn_in(rstn), .img_elec_in(img), .reg_elec_in(regs),
        .supply_in(supply), .viol_out(viol));

    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    // Hang guard: a stuck handshake ends the run as a failure
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic t_power_up();
        int d_at;
        int s_at;
        int p_at;
        d_at = 0;
        s_at = 0;
        p_at = 0;
        @(posedge core_clk) power_req <= 1'b1;
        for (int n = 1; n < 200 && p_at == 0; n++) begin
            @(negedge core_clk);
            if (supply.drains_on === 1'b1 && d_at == 0) d_at = n;
            if (supply.subst_on === 1'b1 && s_at == 0) s_at = n;
            if (powered === 1'b1 && p_at == 0) p_at = n;
        end
        // Request driven at one edge is taken at the next, seen at the second sample
        check("drains first", 16'(d_at), 16'h0002);
        check("substrate delay", 16'(s_at - d_at), 16'(SETTLE + 1));
        check("powered delay", 16'(p_at - s_at), 16'h0001);
    endtask : t_power_up

    task automatic t_integrate();
        @(posedge core_clk) integrate <= 1'b1;
        repeat (3) @(negedge core_clk);
        check("integration phases", 16'(img), {4{4'h6}});
        @(posedge core_clk) integrate <= 1'b0;
    endtask : t_integrate

    task automatic t_line(input logic [3:0] srev, input logic [3:0] hrev, input logic [3:0] sum);
        int bad_img;
        int bad_gate;
        int bad_reg;
        int bad_hold;
        int f_e3;
        int f_well;
        int n;
        logic [3:0] p;
        logic [2:0] r;
        logic pe3;
        logic psw;
        bad_img = 0; bad_gate = 0; bad_reg = 0; bad_hold = 0; f_e3 = 0; f_well = 0; n = 0;
        pe3 = 1'b0;
        psw = 1'b0;
        @(posedge core_clk) begin
            cfg_load <= 1'b1;
            cfg <= '{sec_rev: srev, half_rev: hrev, sum_count: sum, pixels: PIX};
        end
        @(posedge core_clk) begin
            cfg_load <= 1'b0;
            line_start <= 1'b1;
        end
        @(posedge core_clk) line_start <= 1'b0;
        do begin
            @(negedge core_clk);
            p = srev[0] ? rev4(img[0]) : img[0];
            r = regs[0][2:0]; // Half 0 is always reversed, so it shows raw phases
            for (int s = 0; s < NSEC; s++) begin
                if (img[s] !== (srev[s] ? rev4(p) : p)) bad_img++;
            end
            if (tg_up !== (srev[0] ? 1'b0 : p[3]) || tg_lo !== (srev[3] ? 1'b0 : p[0])) bad_gate++;
            for (int h = 0; h < NHALF; h++) begin
                if (regs[h][2:0] !== (hrev[h] ? r : {r[2], r[0], r[1]})) bad_reg++;
                if (p !== 4'h6 && p !== 4'h0 && regs[h][1:0] !== 2'h3) bad_hold++;
            end
            if (pe3 && !r[2]) f_e3++;
            if (psw && !regs[0][3]) f_well++;
            pe3 = r[2];
            psw = regs[0][3];
            n++;
            // Register outputs trail the sequencer by one edge, so wait for them to park too
        end while ((busy === 1'b1 || regs !== '0) && n < 3000);
        check("line ends", 16'(n < 3000), 16'h0001);
        check("image routing", 16'(bad_img), 16'h0000);
        check("transfer gates", 16'(bad_gate), 16'h0000);
        check("register routing", 16'(bad_reg), 16'h0000);
        check("register hold", 16'(bad_hold), 16'h0000);
        check("pixel cycles", 16'(f_e3), 16'(PIX) + 16'h0001);
        check("well releases", 16'(f_well), 16'(PIX) + 16'h0002 - 16'((sum == 4'h0) ? 4'h1 : sum));
    endtask : t_line

    task automatic t_power_down();
        int n;
        n = 0;
        @(posedge core_clk) power_req <= 1'b0;
        do begin
            @(negedge core_clk);
            n++;
        end while (supply.drains_on !== 1'b0 && n < 200);
        check("drains off", 16'(supply), 16'h0000);
    endtask : t_power_down

    // Main sequence: reset, then each scenario in turn
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        check("reset image", 16'(img), 16'h0000);
        check("reset supply", 16'({supply, busy, powered}), 16'h0000);
        t_power_up();
        t_line(4'b1100, 4'b0101, 4'h1);
        t_integrate();
        t_line(4'b0011, 4'b1011, 4'h3);
        t_line(4'b1010, 4'b0111, 4'h0);
        t_power_down();
        check("sensor abuse", 16'(viol), 16'h0000);
        report_and_stop();
    end
endmodule : tb_ccd_readout_clock_router
`default_nettype wire
